// >>> common/sbos_pkg.sv
// constants and types for serializer clock-source select and self-test logic
// assumes a 40 MHz system clock and digitised strap and back-channel levels
package sbos_pkg;
   // register offsets
   localparam logic [7:0] ADDR_CLK_OVR = 8'h03;  // clock override
   localparam logic [7:0] ADDR_STATUS  = 8'h0c;  // live status, read only
   localparam logic [7:0] ADDR_GPO     = 8'h0d;  // general purpose outputs
   localparam logic [7:0] ADDR_OSC_CTL = 8'h14;  // internal oscillator control
   // field positions
   localparam int OVR_BIT = 1;                    // stay on internal oscillator
   localparam int OSC_LSB = 1;                    // select field is [2:1]
   // reset values
   localparam logic [7:0] RST_OSC_CTL  = 8'h02;  // select field 01
   localparam logic [7:0] RST_CLK_OVR  = 8'h00;
   localparam logic [7:0] RST_GPO      = 8'h00;
   // only defined select code: 100 MHz 10-bit, 75 MHz 12-bit
   localparam logic [1:0] OSC_SEL_RUN  = 2'h1;
   // strap ratio in thousandths of supply
   localparam logic [9:0] STRAP_PCLK_MIN = 10'h2ee;  // 0.750
   localparam logic [9:0] STRAP_PCLK_MAX = 10'h3e8;  // 1.000
   localparam logic [9:0] STRAP_EXT_MIN  = 10'h124;  // 0.292
   localparam logic [9:0] STRAP_EXT_MAX  = 10'h153;  // 0.339
   // pixel clock loss timeout
   localparam int MCLK_MHZ       = 40;
   localparam int PCLK_LOSS_NS   = 1000;
   localparam int PCLK_LOSS_CYC  = (PCLK_LOSS_NS * MCLK_MHZ) / 1000;
   localparam logic [5:0] PCLK_LOSS_LAST = 6'(PCLK_LOSS_CYC - 1);
   // serial slave address
   localparam logic [6:0] I2C_DEV_ADDR = 7'h58;
   localparam logic [3:0] I2C_BITS     = 4'h8;
   // serial slave states
   typedef enum logic [2:0] {
      I2_IDLE = 3'h0,
      I2_ADDR = 3'h1,
      I2_ACK  = 3'h2,
      I2_RX   = 3'h3,
      I2_TX   = 3'h4,
      I2_MACK = 3'h5
   } sbos_i2c_e;
   // register write strobe with its data
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } sbos_wr_s;
endpackage : sbos_pkg

// >>> core/sbos_i2c_slave.sv
// serial slave port: pointer write, sequential register write and read
// assumes scl and sda arrive asynchronously; drives sda low only
`timescale 1ns/1ps
`default_nettype none
module sbos_i2c_slave (
   input  wire logic         mclk_i,
   input  wire logic         rst_b_i,
   input  wire logic         ce_i,
   input  wire logic         scl_i,
   input  wire logic         sda_i,
   input  wire logic [7:0]   rdata_i,
   output sbos_pkg::sbos_wr_s wr_o,
   output logic [7:0]        rd_addr_o,
   output logic              sda_oe_o
);
   logic [1:0] scl_s;               // scl synchroniser
   logic [1:0] sda_s;               // sda synchroniser
   logic       scl_q;               // delayed scl for edges
   logic       sda_q;               // delayed sda for edges
   sbos_pkg::sbos_i2c_e st, next_st;
   logic [3:0] bcnt, next_bcnt;     // bits in current byte
   logic [7:0] shreg, next_shreg;   // byte shifter
   logic [7:0] ptr, next_ptr;       // register pointer
   logic       got_ptr, next_got_ptr;
   logic       rw, next_rw;         // 1 for a read transfer
   logic       next_oe;
   sbos_pkg::sbos_wr_s next_wr;
   logic rise, fall, start, stop;
   // fast mode
   // 40 MHz oversampling keeps 400 kbps bit cells many samples wide
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_s <= {scl_s[0], scl_i};
         sda_s <= {sda_s[0], sda_i};
         scl_q <= scl_s[1];
         sda_q <= sda_s[1];
      end
   end
   assign rise  = scl_s[1] & ~scl_q;
   assign fall  = ~scl_s[1] & scl_q;
   assign start = scl_s[1] & scl_q & sda_q & ~sda_s[1];
   assign stop  = scl_s[1] & scl_q & ~sda_q & sda_s[1];
   assign rd_addr_o = ptr;
   // protocol sequencing; data changes only after scl falls
   always_comb
   begin
      next_st      = st;
      next_bcnt    = bcnt;
      next_shreg   = shreg;
      next_ptr     = ptr;
      next_got_ptr = got_ptr;
      next_rw      = rw;
      next_oe      = sda_oe_o;
      next_wr      = '0;
      if (start)
      begin
         next_st      = sbos_pkg::I2_ADDR;
         next_bcnt    = 4'h0;
         next_got_ptr = 1'b0;
         next_oe      = 1'b0;
      end
      else if (stop)
      begin
         next_st = sbos_pkg::I2_IDLE;
         next_oe = 1'b0;
      end
      else if (rise)
      begin
         if (st == sbos_pkg::I2_ADDR || st == sbos_pkg::I2_RX)
         begin
            next_shreg = {shreg[6:0], sda_s[1]};
            next_bcnt  = bcnt + 4'h1;
         end
         else if (st == sbos_pkg::I2_TX)
            next_bcnt = bcnt + 4'h1;
         else if (st == sbos_pkg::I2_MACK && sda_s[1])
            next_st = sbos_pkg::I2_IDLE;  // master refused more data
      end
      else if (fall)
      begin
         unique case (st)
            sbos_pkg::I2_IDLE: ;
            sbos_pkg::I2_ADDR:
               if (bcnt == sbos_pkg::I2C_BITS)
               begin
                  if (shreg[7:1] == sbos_pkg::I2C_DEV_ADDR)
                  begin
                     next_oe = 1'b1;
                     next_rw = shreg[0];
                     next_st = sbos_pkg::I2_ACK;
                  end
                  else
                     next_st = sbos_pkg::I2_IDLE;
               end
            sbos_pkg::I2_RX:
               if (bcnt == sbos_pkg::I2C_BITS)
               begin
                  next_oe = 1'b1;
                  next_st = sbos_pkg::I2_ACK;
                  if (got_ptr)
                  begin
                     next_wr.wr   = 1'b1;
                     next_wr.addr = ptr;
                     next_wr.data = shreg;
                     next_ptr     = ptr + 8'h01;
                  end
                  else
                  begin
                     next_ptr     = shreg;
                     next_got_ptr = 1'b1;
                  end
               end
            sbos_pkg::I2_ACK, sbos_pkg::I2_MACK:
            begin
               next_bcnt = 4'h0;
               if (rw)
               begin
                  next_shreg = rdata_i;
                  next_oe    = ~rdata_i[7];
                  next_ptr   = ptr + 8'h01;
                  next_st    = sbos_pkg::I2_TX;
               end
               else
               begin
                  next_oe = 1'b0;
                  next_st = sbos_pkg::I2_RX;
               end
            end
            sbos_pkg::I2_TX:
               if (bcnt == sbos_pkg::I2C_BITS)
               begin
                  next_oe = 1'b0;
                  next_st = sbos_pkg::I2_MACK;
               end
               else
               begin
                  next_shreg = {shreg[6:0], 1'b0};
                  next_oe    = ~shreg[6];
               end
            default: next_st = sbos_pkg::I2_IDLE;
         endcase
      end
   end
   // protocol state registers
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         st       <= sbos_pkg::I2_IDLE;
         bcnt     <= 4'h0;
         shreg    <= 8'h00;
         ptr      <= 8'h00;
         got_ptr  <= 1'b0;
         rw       <= 1'b0;
         sda_oe_o <= 1'b0;
         wr_o     <= '0;
      end
      else if (ce_i)
      begin
         st       <= next_st;
         bcnt     <= next_bcnt;
         shreg    <= next_shreg;
         ptr      <= next_ptr;
         got_ptr  <= next_got_ptr;
         rw       <= next_rw;
         sda_oe_o <= next_oe;
         wr_o     <= next_wr;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   property p_oe_on_fall;
      $rose(sda_oe_o) |-> $past(fall);
   endproperty
   a_oe_on_fall: assert property (p_oe_on_fall) else $error("sda driven off scl low");
   property p_stop_release;
      (ce_i && stop) |=> !sda_oe_o;
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("sda held after stop");
endmodule : sbos_i2c_slave
`default_nettype wire

// >>> core/sbos_top.sv
// serializer clock-source selection, self-test pattern control, registers
// assumes back-channel levels, strap ratio and pixel clock are asynchronous
`timescale 1ns/1ps
`default_nettype none
module sbos_top (
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   input  wire logic       ce_i,
   input  wire logic       pclk_pin_i,        // pixel clock pin
   input  wire logic [9:0] mode_strap_i,      // strap ratio, thousandths
   input  wire logic       bc_bist_i,         // back channel test command
   input  wire logic [1:0] bc_osc_sel_i,      // back channel osc select
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   output logic            use_internal_osc_o,
   output logic [1:0]      osc_sel_o,
   output logic            osc_rate_ok_o,
   output logic            pattern_enable_o,
   output logic            ext_osc_mode_o,
   output logic            strap_valid_o,
   output logic [3:0]      gpo_o
);
   // input synchronisers
   logic [1:0] pclk_s;                // pixel clock pin
   logic       pclk_q;                // previous synced level
   logic [1:0] bist_s;                // test command level
   logic [1:0] sel_s1;                // select, first stage
   logic [1:0] sel_s2;                // select, second stage
   logic [9:0] strap_s1;              // strap, first stage
   logic [9:0] strap_s2;              // strap, second stage
   logic       pclk_edge;
   logic       bist_on;
   // pixel clock detector
   logic [5:0] idle_cnt, next_idle_cnt;
   logic       pclk_present, next_pclk_present;
   // registers and derived state
   logic [7:0] osc_ctl, next_osc_ctl;
   logic [7:0] clk_ovr, next_clk_ovr;
   logic [7:0] gpo, next_gpo;
   logic       strap_done, next_strap_done;
   logic       next_ext_mode;
   logic       next_strap_valid;
   logic       next_use_int;
   logic       next_rate_ok;
   logic       next_pattern;
   // serial port
   sbos_pkg::sbos_wr_s wr;
   logic [7:0] rd_addr;
   logic [7:0] rdata;
   logic       strap_pclk, strap_ext;
   // strap and command levels cross in two stages; the strap is static
   // so bitwise sampling of a multi-bit bus is safe, and the select
   // only matters while the command level is already stable
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         pclk_s   <= 2'h0;
         pclk_q   <= 1'b0;
         bist_s   <= 2'h0;
         sel_s1   <= 2'h0;
         sel_s2   <= 2'h0;
         // strap keeps sampling in reset so release decodes the pin, not zero
         strap_s1 <= mode_strap_i;
         strap_s2 <= strap_s1;
      end
      else if (ce_i)
      begin
         pclk_s   <= {pclk_s[0], pclk_pin_i};
         pclk_q   <= pclk_s[1];
         bist_s   <= {bist_s[0], bc_bist_i};
         sel_s1   <= bc_osc_sel_i;
         sel_s2   <= sel_s1;
         strap_s1 <= mode_strap_i;
         strap_s2 <= strap_s1;
      end
   end
   assign pclk_edge = pclk_s[1] ^ pclk_q;
   assign bist_on   = bist_s[1];
   // pixel clock presence: any edge sets, a quiet timeout clears
   always_comb
   begin
      next_idle_cnt     = idle_cnt;
      next_pclk_present = pclk_present;
      if (pclk_edge)
      begin
         next_idle_cnt     = 6'h00;
         next_pclk_present = 1'b1;
      end
      else if (idle_cnt == sbos_pkg::PCLK_LOSS_LAST)
         next_pclk_present = 1'b0;
      else
         next_idle_cnt = idle_cnt + 6'h01;
   end
   // detector registers
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         idle_cnt     <= 6'h00;
         pclk_present <= 1'b0;
      end
      else if (ce_i)
      begin
         idle_cnt     <= next_idle_cnt;
         pclk_present <= next_pclk_present;
      end
   end
   // strap windows; a ratio between windows is flagged invalid
   assign strap_pclk = (strap_s2 >= sbos_pkg::STRAP_PCLK_MIN) &&
                       (strap_s2 <= sbos_pkg::STRAP_PCLK_MAX);
   assign strap_ext  = (strap_s2 >= sbos_pkg::STRAP_EXT_MIN) &&
                       (strap_s2 <= sbos_pkg::STRAP_EXT_MAX);
   // register writes, strap capture and clock source choice
   always_comb
   begin
      next_osc_ctl     = osc_ctl;
      next_clk_ovr     = clk_ovr;
      next_gpo         = gpo;
      next_strap_done  = strap_done;
      next_ext_mode    = ext_osc_mode_o;
      next_strap_valid = strap_valid_o;
      if (wr.wr)
      begin
         if (wr.addr == sbos_pkg::ADDR_CLK_OVR)
            next_clk_ovr = wr.data;
         else if (wr.addr == sbos_pkg::ADDR_GPO)
            next_gpo = wr.data;
         else if (wr.addr == sbos_pkg::ADDR_OSC_CTL && !bist_on)
            next_osc_ctl = wr.data;
      end
      // remote select load
      // local writes lose to the far end so both ends agree on rate
      if (bist_on)
         next_osc_ctl[sbos_pkg::OSC_LSB +: 2] = sel_s2;
      // strap decode
      // caught once, on the first enabled cycle after release, then held
      if (!strap_done)
      begin
         next_strap_done  = 1'b1;
         next_ext_mode    = strap_ext;
         next_strap_valid = strap_pclk | strap_ext;
      end
      next_use_int = !pclk_present || clk_ovr[sbos_pkg::OVR_BIT] ||
                     (bist_on && osc_ctl[sbos_pkg::OSC_LSB +: 2] == sbos_pkg::OSC_SEL_RUN);
      next_rate_ok = osc_ctl[sbos_pkg::OSC_LSB +: 2] == sbos_pkg::OSC_SEL_RUN;
      next_pattern = bist_on;
   end
   // configuration registers
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         osc_ctl            <= sbos_pkg::RST_OSC_CTL;
         clk_ovr            <= sbos_pkg::RST_CLK_OVR;
         gpo                <= sbos_pkg::RST_GPO;
         strap_done         <= 1'b0;
         ext_osc_mode_o     <= 1'b0;
         strap_valid_o      <= 1'b0;
         use_internal_osc_o <= 1'b1;
         osc_rate_ok_o      <= 1'b0;
         pattern_enable_o   <= 1'b0;
      end
      else if (ce_i)
      begin
         osc_ctl            <= next_osc_ctl;
         clk_ovr            <= next_clk_ovr;
         gpo                <= next_gpo;
         strap_done         <= next_strap_done;
         ext_osc_mode_o     <= next_ext_mode;
         strap_valid_o      <= next_strap_valid;
         use_internal_osc_o <= next_use_int;
         osc_rate_ok_o      <= next_rate_ok;
         pattern_enable_o   <= next_pattern;
      end
   end
   assign osc_sel_o = osc_ctl[sbos_pkg::OSC_LSB +: 2];
   assign gpo_o     = gpo[3:0];
   assign sda_o     = 1'b0;
   // read mux; unmapped offsets read zero
   always_comb
   begin
      unique case (rd_addr)
         sbos_pkg::ADDR_CLK_OVR: rdata = clk_ovr;
         sbos_pkg::ADDR_OSC_CTL: rdata = osc_ctl;
         sbos_pkg::ADDR_GPO:     rdata = gpo;
         sbos_pkg::ADDR_STATUS:  rdata = {2'h0, strap_valid_o, ext_osc_mode_o,
                                          pattern_enable_o, bist_on,
                                          use_internal_osc_o, pclk_present};
         default:                rdata = 8'h00;
      endcase
   end
   sbos_i2c_slave u_i2c (
      .mclk_i    (mclk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .rdata_i   (rdata),
      .wr_o      (wr),
      .rd_addr_o (rd_addr),
      .sda_oe_o  (sda_oe_o)
   );
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_quiet;
      ce_i && !pclk_edge && idle_cnt == sbos_pkg::PCLK_LOSS_LAST;
   endsequence
   sequence s_bist_load;
      ce_i && bist_on;
   endsequence
   property p_edge_present;
      (ce_i && pclk_edge) |=> pclk_present && idle_cnt == 6'h00;
   endproperty
   a_edge_present: assert property (p_edge_present) else $error("edge not seen");
   property p_loss;
      s_quiet |=> !pclk_present;
   endproperty
   a_loss: assert property (p_loss) else $error("pixel clock loss missed");
   property p_no_pclk_int;
      (ce_i && !pclk_present) |=> use_internal_osc_o;
   endproperty
   a_no_pclk_int: assert property (p_no_pclk_int) else $error("no internal osc");
   property p_pclk_switch;
      (ce_i && pclk_present && !clk_ovr[sbos_pkg::OVR_BIT] && !bist_on) |=> !use_internal_osc_o;
   endproperty
   a_pclk_switch: assert property (p_pclk_switch) else $error("no switch to pclk");
   property p_bist_load;
      s_bist_load |=> osc_sel_o == $past(sel_s2);
   endproperty
   a_bist_load: assert property (p_bist_load) else $error("remote select lost");
   property p_local_sel;
      (ce_i && !bist_on && wr.wr && wr.addr == sbos_pkg::ADDR_OSC_CTL) |=>
         osc_sel_o == $past(wr.data[2:1]);
   endproperty
   a_local_sel: assert property (p_local_sel) else $error("local select lost");
   property p_pattern;
      s_bist_load ##1 (ce_i && bist_on) |=> pattern_enable_o [*1];
   endproperty
   a_pattern: assert property (p_pattern) else $error("pattern not enabled");
   property p_strap;
      (ce_i && !strap_done) |=> ext_osc_mode_o == $past(strap_ext) && strap_done;
   endproperty
   a_strap: assert property (p_strap) else $error("strap decode wrong");
endmodule : sbos_top
`default_nettype wire

// >>> verification/sbos_deser_model.sv
// remote deserializer model: picks the self-test clock code, sends back-channel levels
// assumes the bench drives its pins and register field on the falling edge of mclk_i
`timescale 1ns/1ps
`default_nettype none
module sbos_deser_model #(
   parameter int LAG = 3                                // back-channel delay in cycles, 2 or more
) (
   input  wire logic       mclk_i,
   input  wire logic       self_test_enable_pin_i,
   input  wire logic       test_clock_source_pin0_i,
   input  wire logic       test_clock_source_pin1_i,
   input  wire logic       reg_cfg_i,                   // high = control register drives config
   input  wire logic [1:0] reg_clk_sel_i,               // control register clock field [2:1]
   input  wire logic       pattern_i,                   // serializer test pattern on the forward link
   input  wire logic       frame_err_i,                 // bench marks the current frame errored
   output logic            pass_o,                      // pass indicator pin
   output logic [7:0]      err_cnt_o,                   // errored-frame count register
   output logic            bc_bist_o,
   output logic [1:0]      bc_osc_sel_o
);
   logic [1:0]     cfg_sel;                             // test clock code chosen locally
   logic [LAG-1:0] bist_pipe;                           // channel latency for the enable level
   logic [1:0]     sel_pipe [LAG];                      // channel latency for the clock code
   logic           run_q;                               // checking active last cycle
   // idle channel: no test, select 01 so the far end starts sane
   initial
   begin
      bist_pipe = '0;
      run_q     = 1'b0;
      pass_o    = 1'b0;
      err_cnt_o = 8'h00;
      for (int i = 0; i < LAG; i++)
         sel_pipe[i] = 2'h1;
   end
   always_comb
   begin
      if (reg_cfg_i)
         cfg_sel = reg_clk_sel_i;                       // register field passed as written
      else
         cfg_sel = {test_clock_source_pin1_i, test_clock_source_pin0_i};
   end
   // checking runs while enable pin and pattern are both up
   // one count per errored frame, stuck at the top
   // count kept after the run; pass not held once checking stops
   always @(posedge mclk_i)
   begin
      run_q  <= self_test_enable_pin_i & pattern_i;
      pass_o <= run_q & !frame_err_i;
      if (self_test_enable_pin_i & pattern_i & !run_q)
         err_cnt_o <= 8'h00;                            // new session clears the count
      else if (run_q & frame_err_i & (err_cnt_o != 8'hff))
         err_cnt_o <= err_cnt_o + 8'h01;
   end
   // enable and select cross the back channel
   // sampled on the rising edge so bench pins set on the falling edge never race
   always @(posedge mclk_i)
   begin
      bist_pipe <= {bist_pipe[LAG-2:0], self_test_enable_pin_i};
      sel_pipe[0] <= cfg_sel;
      for (int i = 1; i < LAG; i++)
         sel_pipe[i] <= sel_pipe[i-1];
   end
   assign bc_bist_o    = bist_pipe[LAG-1];
   assign bc_osc_sel_o = sel_pipe[LAG-1];
endmodule : sbos_deser_model
`default_nettype wire

// >>> verification/sbos_top_tb.sv
// self-checking bench for the clock-source select and self-test control block
// assumes the bench is the serial master; sda line level is master AND slave pull-down
`timescale 1ns/1ps
`default_nettype none
module sbos_top_tb;
   logic       mclk = 1'b0;                             // 40 MHz system clock
   logic       rst_b = 1'b0;
   logic       pclk = 1'b0;                             // pixel clock pin, 200 ns period
   logic       pclk_run = 1'b0;
   logic       scl = 1'b1;
   logic       sda_m = 1'b1;                            // master side of sda, 1 = released
   logic       en = 1'b0;                               // far end self-test enable pin
   logic       p0 = 1'b0;
   logic       p1 = 1'b0;
   logic       rcfg = 1'b0;                             // far end uses its register
   logic [1:0] rsel = 2'h1;
   logic       ferr = 1'b0;                             // far end sees an errored frame
   logic       pass;
   logic [7:0] err_cnt;
   logic [9:0] strap = 10'h12c;                         // 300 thousandths: external oscillator window
   logic       bc_bist;
   logic [1:0] bc_sel;
   logic       sda_o, sda_oe, use_int, rate_ok, pattern, ext_mode, strap_ok;
   logic [1:0] osc_sel;
   logic [3:0] gpo;
   wire        sda_line;
   int         fails = 0;
   int         compares = 0;
   // open-drain line: pull-up unless someone pulls low
   assign sda_line = sda_m & (sda_oe ? sda_o : 1'b1);
   always #12.5 mclk = ~mclk;
   // pixel clock offset from mclk so edges never share a time step
   initial
   begin
      #13;
      forever #100 if (pclk_run) pclk = ~pclk;
   end
   sbos_deser_model #(.LAG(3)) far_u (
      .mclk_i(mclk), .self_test_enable_pin_i(en), .test_clock_source_pin0_i(p0),
      .test_clock_source_pin1_i(p1), .reg_cfg_i(rcfg), .reg_clk_sel_i(rsel),
      .pattern_i(pattern), .frame_err_i(ferr), .pass_o(pass), .err_cnt_o(err_cnt),
      .bc_bist_o(bc_bist), .bc_osc_sel_o(bc_sel));
   sbos_top dut_u (
      .mclk_i(mclk), .rst_b_i(rst_b), .ce_i(1'b1), .pclk_pin_i(pclk), .mode_strap_i(strap),
      .bc_bist_i(bc_bist), .bc_osc_sel_i(bc_sel), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .use_internal_osc_o(use_int), .osc_sel_o(osc_sel),
      .osc_rate_ok_o(rate_ok), .pattern_enable_o(pattern), .ext_osc_mode_o(ext_mode),
      .strap_valid_o(strap_ok), .gpo_o(gpo));
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   // one serial bit, 100 mclk long (400 kbps); line sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      cyc(25);
      scl = 1'b1;
      cyc(25);
      r = sda_line;
      cyc(25);
      scl = 1'b0;
      cyc(25);
   endtask : bit_io
   task automatic start_c;
      sda_m = 1'b1;
      cyc(25);
      scl = 1'b1;
      cyc(25);
      sda_m = 1'b0;
      cyc(25);
      scl = 1'b0;
   endtask : start_c
   task automatic stop_c;
      sda_m = 1'b0;
      cyc(25);
      scl = 1'b1;
      cyc(25);
      sda_m = 1'b1;
      cyc(25);
   endtask : stop_c
   // byte out MSB first, master always releases the ninth bit
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], b);
         r[i] = b;
      end
      bit_io(1'b1, b);
      ack = ~b;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic k0, k1, k2;
      start_c();
      xfer({sbos_pkg::I2C_DEV_ADDR, 1'b0}, r, k0);
      xfer(a, r, k1);
      xfer(d, r, k2);
      stop_c();
      chk("write acks", 8'h07, {5'h0, k0, k1, k2});
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic k;
      start_c();
      xfer({sbos_pkg::I2C_DEV_ADDR, 1'b0}, r, k);
      xfer(a, r, k);
      start_c();
      xfer({sbos_pkg::I2C_DEV_ADDR, 1'b1}, r, k);
      xfer(8'hff, d, k);
      stop_c();
   endtask : rd
   task automatic t_reset;
      chk("use_int", 8'h01, 8'(use_int));
      chk("osc_sel", 8'h01, 8'(osc_sel));
      chk("rate_ok", 8'h01, 8'(rate_ok));
      chk("pattern", 8'h00, 8'(pattern));
      chk("sda_oe", 8'h00, 8'(sda_oe));
      chk("ext_mode", 8'h01, 8'(ext_mode));
      chk("strap_ok", 8'h01, 8'(strap_ok));
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs;
      logic [7:0] d;
      logic [7:0] r;
      logic k;
      wr(sbos_pkg::ADDR_GPO, 8'h0a);
      chk("gpo", 8'h0a, 8'(gpo));
      wr(sbos_pkg::ADDR_OSC_CTL, 8'h00);
      chk("rate_ok", 8'h00, 8'(rate_ok));
      rd(sbos_pkg::ADDR_OSC_CTL, d);
      chk("osc_ctl", 8'h00, d);
      chk("sda_o", 8'h00, 8'(sda_o));
      wr(sbos_pkg::ADDR_OSC_CTL, 8'h06);
      chk("rate_ok", 8'h00, 8'(rate_ok));
      wr(sbos_pkg::ADDR_OSC_CTL, 8'h02);
      chk("rate_ok", 8'h01, 8'(rate_ok));
      chk("osc_sel", 8'h01, 8'(osc_sel));
      rd(sbos_pkg::ADDR_STATUS, d);
      chk("status", 8'h32, d);
      rd(8'h20, d);
      chk("unmapped", 8'h00, d);
      // a foreign address must not be acknowledged
      start_c();
      xfer({sbos_pkg::I2C_DEV_ADDR + 7'h1, 1'b0}, r, k);
      stop_c();
      chk("foreign ack", 8'h00, 8'(k));
      $display("test regs done");
   endtask : t_regs
   task automatic t_pclk;
      pclk_run = 1'b1;
      cyc(40);
      chk("use_int", 8'h00, 8'(use_int));
      wr(sbos_pkg::ADDR_CLK_OVR, 8'h02);
      chk("use_int", 8'h01, 8'(use_int));
      wr(sbos_pkg::ADDR_CLK_OVR, 8'h00);
      chk("use_int", 8'h00, 8'(use_int));
      // loss is declared only after 40 quiet cycles
      pclk_run = 1'b0;
      cyc(28);
      chk("use_int", 8'h00, 8'(use_int));
      cyc(32);
      chk("use_int", 8'h01, 8'(use_int));
      $display("test pclk done");
   endtask : t_pclk
   task automatic t_bist;
      pclk_run = 1'b1;
      rcfg = 1'b1;
      en = 1'b1;
      cyc(12);
      chk("pattern", 8'h01, 8'(pattern));
      chk("use_int", 8'h01, 8'(use_int));
      chk("pass", 8'h01, 8'(pass));
      // two errored frames: pass dips, count steps twice
      ferr = 1'b1;
      cyc(1);
      chk("pass", 8'h00, 8'(pass));
      cyc(1);
      ferr = 1'b0;
      cyc(1);
      chk("pass", 8'h01, 8'(pass));
      chk("err_cnt", 8'h02, err_cnt);
      // a long burst must stick at the top, not wrap
      ferr = 1'b1;
      cyc(260);
      ferr = 1'b0;
      chk("err_cnt", 8'hff, err_cnt);
      wr(sbos_pkg::ADDR_OSC_CTL, 8'h00);
      chk("osc_sel", 8'h01, 8'(osc_sel));
      // pins 00 hand the test clock to the pixel clock
      rcfg = 1'b0;
      cyc(12);
      chk("osc_sel", 8'h00, 8'(osc_sel));
      chk("use_int", 8'h00, 8'(use_int));
      en = 1'b0;
      cyc(12);
      chk("pattern", 8'h00, 8'(pattern));
      chk("pass", 8'h00, 8'(pass));
      chk("err_cnt", 8'hff, err_cnt);
      pclk_run = 1'b0;
      $display("test bist done");
   endtask : t_bist
   // mid-run reset with the strap in the pixel clock window, then between windows
   task automatic t_strap;
      strap = 10'h320;
      rst_b = 1'b0;
      cyc(4);
      rst_b = 1'b1;
      cyc(2);
      chk("ext_mode", 8'h00, 8'(ext_mode));
      chk("strap_ok", 8'h01, 8'(strap_ok));
      chk("osc_sel", 8'h01, 8'(osc_sel));
      chk("gpo", 8'h00, 8'(gpo));
      strap = 10'h200;
      rst_b = 1'b0;
      cyc(4);
      rst_b = 1'b1;
      cyc(2);
      chk("strap_ok", 8'h00, 8'(strap_ok));
      $display("test strap done");
   endtask : t_strap
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   initial
   begin
      cyc(16);
      rst_b = 1'b1;
      cyc(4);
      t_reset();
      t_regs();
      t_pclk();
      t_bist();
      t_strap();
      summarize();
   end
   // expected run is under 0.9 ms
   initial
   begin
      #2_000_000;
      fails++;
      summarize();
   end
endmodule : sbos_top_tb
`default_nettype wire
